// ==== shared/sdram_lp_pkg.sv ====
// constants, types and register map of the sdram low-power state controller
package sdram_lp_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_CKE_PS      = 5000;
  // longest time for the first internal refresh: round down, at least one cycle
  localparam int TCKE_CYC      = (T_CKE_PS / CLK_PERIOD_PS) < 1 ? 1 : (T_CKE_PS / CLK_PERIOD_PS);
  localparam int T_CPDED_NCK   = 1;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTRL_OFFSET        = 8'h00;
  localparam logic [7:0]  REF_INTERVAL_OFFSET = 8'h04;
  localparam logic [7:0]  STATUS_OFFSET      = 8'h08;
  localparam logic [7:0]  REF_COUNT_OFFSET   = 8'h0C;
  localparam int          CTRL_CLR_POS       = 0;
  localparam logic [15:0] REF_INTERVAL_RESET = 16'h03CF;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;

  // ----------------------------------------------------------------
  // mode-register fields captured from mode-register writes
  // ----------------------------------------------------------------
  localparam logic [2:0]  MR0_SEL            = 3'h0;
  localparam logic [2:0]  MR1_SEL            = 3'h1;
  localparam logic        MR0_PPD_RESET      = 1'b0;
  localparam logic        MR1_DLL_DIS_RESET  = 1'b0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       cs_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic [2:0] ba;
    logic       a12;
    logic       a10;
    logic       a0;
  } ddr_cmd_t;

  typedef enum logic [5:0] {
    ST_RESET = 6'h01,
    ST_IDLE  = 6'h02,
    ST_ACT   = 6'h04,
    ST_SR    = 6'h08,
    ST_APD   = 6'h10,
    ST_PPD   = 6'h20
  } power_state_t;

  typedef struct packed {
    logic [7:0] banks_open;
    logic       cmd_rx_on;
    logic       slow_exit;
    logic       mr0_ppd_fast;
    logic       mr1_dll_dis;
    logic       dll_on;
    logic [5:0] state;
  } status_t;

endpackage

// ==== verilog/sdram_self_refresh_power_down.sv ====
// low-power state control of a ddr3 sdram: self-refresh and power-down
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module sdram_self_refresh_power_down
  import sdram_lp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // ddr command side
  input  wire logic        cke,
  input  wire ddr_cmd_t    cmd,
  input  wire logic        dram_reset_n,
  output logic [5:0]       power_state,
  output logic             dll_on,
  output logic             dll_reset_pulse,
  output logic             internal_refresh,
  output logic             cmd_rx_on,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  power_state_t state_reg;
  logic         cke_prev_reg;
  logic [7:0]   banks_open_reg;
  logic         mr0_ppd_fast_reg;
  logic         mr1_dll_dis_reg;
  logic         slow_exit_reg;
  logic [15:0]  ref_timer_reg;
  logic [15:0]  ref_interval_reg;
  logic [31:0]  ref_count_reg;
  logic [1:0]   cpded_cnt_reg;
  logic         clr_count;

  logic is_nop;
  logic is_ref;
  logic is_act;
  logic is_pre;
  logic is_mrs;
  logic sre_taken;
  logic pde_taken;
  logic exit_taken;
  logic cke_steady;

  assign is_nop     = cmd.cs_n | (cmd.ras_n & cmd.cas_n & cmd.we_n);
  assign is_ref     = !cmd.cs_n & !cmd.ras_n & !cmd.cas_n & cmd.we_n;
  assign is_act     = !cmd.cs_n & !cmd.ras_n & cmd.cas_n & cmd.we_n;
  assign is_pre     = !cmd.cs_n & !cmd.ras_n & cmd.cas_n & !cmd.we_n;
  assign is_mrs     = !cmd.cs_n & !cmd.ras_n & !cmd.cas_n & !cmd.we_n;
  assign cke_steady = cke_prev_reg & cke;
  // self-refresh entry is the refresh pattern with cke falling
  assign sre_taken  = (state_reg == ST_IDLE) & cke_prev_reg & !cke & is_ref;
  assign pde_taken  = ((state_reg == ST_IDLE) | (state_reg == ST_ACT)) & cke_prev_reg & !cke & is_nop;
  // self-refresh exit looks at cke only; power-down exit also needs nop
  assign exit_taken = ((state_reg == ST_SR) & cke) |
                      (((state_reg == ST_APD) | (state_reg == ST_PPD)) & cke & is_nop);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cke_prev_reg <= 1'b0;
    end else begin
      cke_prev_reg <= cke;
    end
  end

  // ----------------------------------------------------------------
  // power state
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_RESET;
    end else if (!dram_reset_n) begin
      state_reg <= ST_RESET;
    end else begin
      case (state_reg)
        ST_RESET: begin
          state_reg <= ST_IDLE;
        end
        ST_IDLE, ST_ACT: begin
          if (sre_taken) begin
            state_reg <= ST_SR;
          end else if (pde_taken) begin
            // bank state decides the kind of power-down
            state_reg <= (banks_open_reg != 8'h00) ? ST_APD : ST_PPD;
          end else if (banks_open_reg != 8'h00) begin
            state_reg <= ST_ACT;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        ST_SR: begin
          if (exit_taken) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_APD: begin
          if (exit_taken) begin
            state_reg <= ST_ACT;
          end
        end
        ST_PPD: begin
          if (exit_taken) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_RESET;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // banks and mode bits
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !dram_reset_n || state_reg == ST_RESET) begin
      banks_open_reg <= 8'h00;
    end else if (cke_steady && (state_reg == ST_IDLE || state_reg == ST_ACT)) begin
      if (is_act) begin
        banks_open_reg[cmd.ba] <= 1'b1;
      end else if (is_pre && cmd.a10) begin
        banks_open_reg <= 8'h00;
      end else if (is_pre) begin
        banks_open_reg[cmd.ba] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !dram_reset_n) begin
      mr0_ppd_fast_reg <= MR0_PPD_RESET;
      mr1_dll_dis_reg  <= MR1_DLL_DIS_RESET;
    end else if (cke_steady && is_mrs && state_reg == ST_IDLE) begin
      if (cmd.ba == MR0_SEL) begin
        mr0_ppd_fast_reg <= cmd.a12;
      end
      if (cmd.ba == MR1_SEL) begin
        mr1_dll_dis_reg <= cmd.a0;
      end
    end
  end

  // ----------------------------------------------------------------
  // dll control
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !dram_reset_n) begin
      dll_on          <= 1'b0;
      dll_reset_pulse <= 1'b0;
      slow_exit_reg   <= 1'b0;
    end else begin
      dll_reset_pulse <= 1'b0;
      if (state_reg == ST_RESET) begin
        dll_on <= !MR1_DLL_DIS_RESET;
      end else if (sre_taken) begin
        dll_on <= 1'b0;
      end else if (state_reg == ST_SR && exit_taken) begin
        // relock only when the mode register keeps the dll enabled
        dll_on          <= !mr1_dll_dis_reg;
        dll_reset_pulse <= !mr1_dll_dis_reg;
      end else if (pde_taken && banks_open_reg == 8'h00 && !mr0_ppd_fast_reg) begin
        dll_on        <= 1'b0;
        slow_exit_reg <= 1'b1;
      end else if (pde_taken) begin
        slow_exit_reg <= 1'b0;
      end else if (state_reg == ST_PPD && exit_taken && slow_exit_reg) begin
        dll_on <= !mr1_dll_dis_reg;
      end else if (cke_steady && is_mrs && cmd.ba == MR1_SEL && state_reg == ST_IDLE) begin
        dll_on <= !cmd.a0;
      end
    end
  end

  // ----------------------------------------------------------------
  // receivers and internal refresh timer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_rx_on     <= 1'b0;
      cpded_cnt_reg <= 2'h0;
    end else if (state_reg == ST_SR || state_reg == ST_APD || state_reg == ST_PPD) begin
      // receivers stay on through tcpded so nops after cke falls are still seen
      if (exit_taken) begin
        cmd_rx_on <= 1'b1;
      end else if (cpded_cnt_reg >= 2'(T_CPDED_NCK)) begin
        cmd_rx_on <= 1'b0;
      end else begin
        cpded_cnt_reg <= cpded_cnt_reg + 2'h1;
      end
    end else begin
      cmd_rx_on     <= (state_reg != ST_RESET);
      cpded_cnt_reg <= 2'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_timer_reg    <= 16'h0000;
      internal_refresh <= 1'b0;
      ref_count_reg    <= 32'h0000_0000;
    end else begin
      internal_refresh <= 1'b0;
      if (sre_taken) begin
        ref_timer_reg <= 16'(TCKE_CYC - 1);
      end else if (state_reg == ST_SR && !exit_taken) begin
        if (ref_timer_reg == 16'h0000) begin
          internal_refresh <= 1'b1;
          ref_timer_reg    <= ref_interval_reg;
        end else begin
          ref_timer_reg <= ref_timer_reg - 16'h0001;
        end
      end
      if (clr_count) begin
        ref_count_reg <= 32'h0000_0000;
      end else if (state_reg == ST_SR && !exit_taken && ref_timer_reg == 16'h0000) begin
        ref_count_reg <= ref_count_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_state <= 6'h01;
    end else begin
      power_state <= state_reg;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic [7:0]  wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0]  wr_strb_reg;
  logic        aw_got_reg;
  logic        w_got_reg;
  logic        wr_fire;

  assign wr_fire   = aw_got_reg & w_got_reg & !s_axi_bvalid;
  assign clr_count = wr_fire & (wr_addr_reg == CTRL_OFFSET) & wr_strb_reg[0] & wr_data_reg[CTRL_CLR_POS];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      wr_addr_reg   <= 8'h00;
      wr_data_reg   <= 32'h0000_0000;
      wr_strb_reg   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg    <= 1'b1;
        s_axi_awready <= 1'b0;
        wr_addr_reg   <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg    <= 1'b1;
        s_axi_wready <= 1'b0;
        wr_data_reg  <= s_axi_wdata;
        wr_strb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= RESP_OKAY;
      ref_interval_reg <= REF_INTERVAL_RESET;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= RESP_OKAY;
      if (wr_addr_reg == REF_INTERVAL_OFFSET) begin
        if (wr_strb_reg[0]) begin
          ref_interval_reg[7:0] <= wr_data_reg[7:0];
        end
        if (wr_strb_reg[1]) begin
          ref_interval_reg[15:8] <= wr_data_reg[15:8];
        end
      end else if (wr_addr_reg != CTRL_OFFSET) begin
        s_axi_bresp <= RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  status_t status;

  assign status = '{banks_open: banks_open_reg, cmd_rx_on: cmd_rx_on, slow_exit: slow_exit_reg,
                    mr0_ppd_fast: mr0_ppd_fast_reg, mr1_dll_dis: mr1_dll_dis_reg,
                    dll_on: dll_on, state: state_reg};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFFSET:         s_axi_rdata <= 32'h0000_0000;
        REF_INTERVAL_OFFSET: s_axi_rdata <= {16'h0000, ref_interval_reg};
        STATUS_OFFSET:       s_axi_rdata <= {13'h0000, status};
        REF_COUNT_OFFSET:    s_axi_rdata <= ref_count_reg;
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ==== testbench/sdram_lp_assertions.sv ====
// concurrent checks of the low-power state control, bound to the device ports
`timescale 1ns/1ps
module sdram_lp_assertions
  import sdram_lp_pkg::*;
(
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       cke,
  input wire ddr_cmd_t   cmd,
  input wire logic       dram_reset_n,
  input wire logic [5:0] power_state,
  input wire logic       dll_on,
  input wire logic       dll_reset_pulse,
  input wire logic       internal_refresh,
  input wire logic       cmd_rx_on
);
  logic cke_reg;
  logic quiet_reg;
  logic fast_reg;
  logic dis_reg;
  wire  nop   = cmd.cs_n | (cmd.ras_n & cmd.cas_n & cmd.we_n);
  wire  ref_p = ~cmd.cs_n & ~cmd.ras_n & ~cmd.cas_n & cmd.we_n;
  // power_state lags two edges, so a quiet edge before the fall pins the real state
  wire  fall  = cke_reg & ~cke & dram_reset_n & quiet_reg;

  always_ff @(posedge aclk) begin
    cke_reg   <= cke;
    quiet_reg <= cke & nop & dram_reset_n;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !dram_reset_n) begin
      fast_reg <= MR0_PPD_RESET;
      dis_reg  <= MR1_DLL_DIS_RESET;
    end else if (cke && cke_reg && cmd[9:6] == 4'h0 && cmd.ba == MR0_SEL) begin
      fast_reg <= cmd.a12;
    end else if (cke && cke_reg && cmd[9:6] == 4'h0 && cmd.ba == MR1_SEL) begin
      // a disabled dll stays off across exits, so expectations follow this bit
      dis_reg <= cmd.a0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence sre_s;
    fall && ref_p && power_state == ST_IDLE;
  endsequence
  sequence pde_s(logic [5:0] s);
    fall && nop && power_state == s;
  endsequence

  a_sre_enter: assert property (sre_s |=> !dll_on ##1 power_state == ST_SR)
    else $error("self-refresh entry not taken");
  a_sre_refresh: assert property (sre_s |-> ##[1:4] internal_refresh)
    else $error("no internal refresh after entry");
  a_sr_ignore: assert property (power_state == ST_SR && !cke && !cke_reg && dram_reset_n && $past(dram_reset_n)
      |=> power_state == ST_SR && !dll_on)
    else $error("self-refresh left while cke low");
  a_sr_exit: assert property (power_state == ST_SR && cke && !cke_reg && dram_reset_n
      |=> dll_on == !dis_reg ##[0:1] dll_reset_pulse == !dis_reg ##[0:1] power_state == ST_IDLE)
    else $error("self-refresh exit wrong");
  a_ppd_enter: assert property (pde_s(ST_IDLE) |=> dll_on == (fast_reg && !dis_reg) ##1 power_state == ST_PPD)
    else $error("precharge power-down entry wrong");
  a_apd_enter: assert property (pde_s(ST_ACT) |=> dll_on == !dis_reg ##1 power_state == ST_APD)
    else $error("active power-down entry wrong");
  a_rx_off: assert property (pde_s(ST_IDLE) |=> cmd_rx_on ##[1:2] !cmd_rx_on)
    else $error("receivers not turned off");
  a_pd_exit: assert property (power_state == ST_PPD && cke && !cke_reg && nop && dram_reset_n
      |=> dll_on == !dis_reg ##1 power_state == ST_IDLE)
    else $error("power-down exit wrong");
  a_reset_pin: assert property (!dram_reset_n |=> !dll_on ##1 power_state == ST_RESET)
    else $error("reset pin ignored");
  a_state_onehot: assert property ($onehot(power_state))
    else $error("state not one-hot");
endmodule

bind sdram_self_refresh_power_down sdram_lp_assertions sdram_lp_assertions_inst (
  .aclk, .aresetn, .cke, .cmd, .dram_reset_n, .power_state,
  .dll_on, .dll_reset_pulse, .internal_refresh, .cmd_rx_on
);

// ==== testbench/sdram_ctrl_model.sv ====
// memory controller model driving clock enable and the command pins
`timescale 1ns/1ps
module sdram_ctrl_model
  import sdram_lp_pkg::*;
(
  input  wire logic aclk,
  output logic      cke,
  output ddr_cmd_t  cmd
);
  // outside self-refresh only nop, refresh, activate, precharge and mode writes are sent: no bursts,
  // no writes, termination never on, no refresh postponed
  // self-refresh re-entry is preceded by an extra refresh well after exit
  initial begin
    cke = 1'b1;
    cmd = 10'h1C0;
  end

  // one command held for n edges, changed just after a rising edge
  task automatic drive(input ddr_cmd_t c, input logic k, input int n);
    repeat (n) begin
      @(posedge aclk);
      cmd <= c;
      cke <= k;
    end
  endtask

  // pins are don't-care in self-refresh, so they wander; a stale level would hide faults
  task automatic noisy(input int n);
    repeat (n) begin
      @(posedge aclk);
      cmd <= cmd + 10'h0C3;
      cke <= 1'b0;
    end
  endtask
endmodule

// ==== testbench/sdram_self_refresh_power_down_tb.sv ====
// self-checking bench of the sdram low-power state control
`timescale 1ns/1ps
module sdram_self_refresh_power_down_tb import sdram_lp_pkg::*;;
  localparam ddr_cmd_t C_NOP = 10'h1C0;
  localparam ddr_cmd_t C_REF = 10'h040;
  localparam ddr_cmd_t C_ACT = 10'h0C0;
  localparam ddr_cmd_t C_PRE = 10'h082;
  localparam ddr_cmd_t C_MRS = 10'h004;
  localparam ddr_cmd_t C_MR1D = 10'h009;
  localparam ddr_cmd_t C_MR1E = 10'h008;
  logic        aclk;
  logic        aresetn      = 1'b0;
  logic        dram_reset_n = 1'b1;
  logic        cke;
  ddr_cmd_t    cmd;
  logic [5:0]  power_state;
  logic        dll_on, dll_reset_pulse, internal_refresh, cmd_rx_on;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          errors  = 0;
  int          checked = 0;
  int          pulses  = 0;
  bit          rstp    = 1'b0;

  sdram_self_refresh_power_down sdram_self_refresh_power_down_inst (
    .aclk(aclk), .aresetn(aresetn), .cke(cke), .cmd(cmd), .dram_reset_n(dram_reset_n),
    .power_state(power_state), .dll_on(dll_on), .dll_reset_pulse(dll_reset_pulse),
    .internal_refresh(internal_refresh), .cmd_rx_on(cmd_rx_on),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready)
  );
  sdram_ctrl_model sdram_ctrl_model_inst (.aclk(aclk), .cke(cke), .cmd(cmd));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (internal_refresh === 1'b1) pulses++;
    if (dll_reset_pulse === 1'b1) rstp = 1'b1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic bit bad(input bit b);
    checked++;
    return b;
  endfunction
  task automatic err(input string m);
    errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic print_verdict;
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic dr(input ddr_cmd_t c, input logic k, input int n);
    sdram_ctrl_model_inst.drive(c, k, n);
  endtask
  task automatic expect_ps(input logic [5:0] s);
    int n;
    n = 0;
    while (power_state !== s && n < 8) begin
      @(negedge aclk);
      n++;
    end
    if (bad(power_state !== s)) err("power state");
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    if (bvalid !== 1'b1) begin
      err("write hang");
      print_verdict;
    end
    if (bad(bresp !== r)) err("write response");
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (rvalid !== 1'b1) begin
      err("read hang");
      print_verdict;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(REF_INTERVAL_OFFSET, d, r);
    if (bad(d !== {16'h0000, REF_INTERVAL_RESET} || r !== RESP_OKAY)) err("interval reset");
    axi_wr(REF_INTERVAL_OFFSET, 32'h00000004, RESP_OKAY);
    axi_rd(STATUS_OFFSET, d, r);
    if (bad(d[5:0] !== ST_IDLE || d[6] !== 1'b1)) err("status");
    axi_wr(STATUS_OFFSET, 32'h0, RESP_SLVERR);
    axi_rd(8'h10, d, r);
    if (bad(r !== RESP_SLVERR)) err("unmapped read");
  endtask
  task automatic t_sr;
    logic [31:0] d;
    logic [1:0]  r;
    dr(C_NOP, 1'b1, 2);
    pulses = 0;
    dr(C_REF, 1'b0, 1);
    expect_ps(ST_SR);
    sdram_ctrl_model_inst.noisy(20);
    if (bad(dll_on !== 1'b0)) err("dll on in self-refresh");
    if (bad(power_state !== ST_SR || cmd_rx_on !== 1'b0)) err("commands not ignored");
    if (bad(pulses < 3 || pulses > 6)) err("internal refresh count");
    axi_rd(REF_COUNT_OFFSET, d, r);
    if (bad((d >= 32'h00000003) !== 1'b1)) err("refresh counter");
    rstp = 1'b0;
    dr(C_NOP, 1'b1, 4);
    expect_ps(ST_IDLE);
    if (bad(dll_on !== 1'b1 || !rstp)) err("dll not restarted");
    axi_wr(CTRL_OFFSET, 32'h00000001, RESP_OKAY);
    axi_rd(REF_COUNT_OFFSET, d, r);
    if (bad(d !== 32'h0)) err("counter clear");
  endtask
  task automatic t_ppd;
    dr(C_NOP, 1'b0, 5);
    expect_ps(ST_PPD);
    if (bad(dll_on !== 1'b0 || cmd_rx_on !== 1'b0)) err("slow power-down");
    dr(C_REF, 1'b1, 1);
    dr(C_NOP, 1'b0, 3);
    if (bad(power_state !== ST_PPD)) err("exit without nop");
    dr(C_NOP, 1'b1, 3);
    expect_ps(ST_IDLE);
    if (bad(dll_on !== 1'b1 || cmd_rx_on !== 1'b1)) err("power-down exit");
  endtask
  task automatic t_fast;
    dr(C_MRS, 1'b1, 1);
    dr(C_NOP, 1'b1, 4);
    dr(C_NOP, 1'b0, 4);
    expect_ps(ST_PPD);
    if (bad(dll_on !== 1'b1)) err("fast exit dll");
    dr(C_NOP, 1'b1, 3);
    expect_ps(ST_IDLE);
  endtask
  task automatic t_apd;
    dr(C_ACT, 1'b1, 1);
    dr(C_NOP, 1'b1, 3);
    expect_ps(ST_ACT);
    dr(C_NOP, 1'b0, 4);
    expect_ps(ST_APD);
    if (bad(dll_on !== 1'b1)) err("active power-down dll");
    dr(C_NOP, 1'b1, 3);
    expect_ps(ST_ACT);
    dr(C_PRE, 1'b1, 1);
    dr(C_NOP, 1'b1, 3);
    expect_ps(ST_IDLE);
  endtask
  task automatic t_rst;
    dr(C_NOP, 1'b0, 4);
    expect_ps(ST_PPD);
    @(posedge aclk);
    dram_reset_n <= 1'b0;
    expect_ps(ST_RESET);
    if (bad(dll_on !== 1'b0)) err("dll after reset pin");
    @(posedge aclk);
    dram_reset_n <= 1'b1;
    dr(C_NOP, 1'b1, 6);
    expect_ps(ST_IDLE);
    dr(C_NOP, 1'b0, 4);
    expect_ps(ST_PPD);
    if (bad(dll_on !== 1'b0)) err("mode bits kept over reset");
    dr(C_NOP, 1'b1, 3);
    expect_ps(ST_IDLE);
  endtask
  task automatic t_dll;
    dr(C_REF, 1'b1, 1);
    dr(C_MR1D, 1'b1, 1);
    dr(C_NOP, 1'b1, 2);
    if (bad(dll_on !== 1'b0)) err("dll disable write");
    rstp = 1'b0;
    dr(C_REF, 1'b0, 1);
    expect_ps(ST_SR);
    sdram_ctrl_model_inst.noisy(4);
    dr(C_NOP, 1'b1, 4);
    expect_ps(ST_IDLE);
    if (bad(dll_on !== 1'b0 || rstp)) err("dll restarted while disabled");
    dr(C_MR1E, 1'b1, 1);
    dr(C_NOP, 1'b1, 2);
    if (bad(dll_on !== 1'b1)) err("dll enable write");
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    t_regs;
    t_sr;
    t_ppd;
    t_fast;
    t_apd;
    t_rst;
    t_dll;
    print_verdict;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err("timeout");
    print_verdict;
  end
endmodule
